/* design/tcip_pkg.sv */
// Shared constants and types for the touch controller two-wire target port
// Notes on behaviour
// [RQ1] Seven address bits, then direction bit, 0=write
// [RQ2] Respond only to address 0111100, any direction
// [RQ3] Start: data falls while clock high
// [RQ4] Stop: data rises while clock high, ends transfer
// [RQ5] Controller sends address byte MSB first, stable
// [RQ6] Target pulls data low on address acknowledge
// [RQ7] Controller stops after address not acknowledged
// [RQ8] Register-address byte follows, target acknowledges it
// [RQ9] Write data bytes MSB first, each acknowledged
// [RQ10] Sample on clock high; change only when low
// [RQ11] Data line released high while bus idle
// [RQ12] Read: write register address, restart, read
// [RQ13] Several data bytes per transfer until stop
// [RQ14] Works with bus clock up to 100 kHz
// [RQ15] Pointer advances per byte; read ends NACK, stop; target leaves it unchanged after the NACKed last read byte
package tcip_pkg;

    localparam logic [6:0] TGT_ADDR = 7'h3c;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic BIT_ACK = 1'b0;
    localparam logic BIT_NACK = 1'b1;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] LEN_ONE = 4'h1;

    // Timing of the generated bus clock
    localparam int CLK_MHZ = 250;
    localparam int SCL_MAX_KHZ = 100;
    localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
    localparam int QTR_NS = SCL_PERIOD_NS / 4;
    localparam int QTR_CYC = (QTR_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        TCIP_T_IDLE,
        TCIP_T_ADDR,
        TCIP_T_ACK_ADDR,
        TCIP_T_REG,
        TCIP_T_ACK_REG,
        TCIP_T_WDATA,
        TCIP_T_ACK_W,
        TCIP_T_RDATA,
        TCIP_T_RACK
    } tcip_tgt_state_t;

    typedef enum logic [1:0] {
        TCIP_H_IDLE,
        TCIP_H_START,
        TCIP_H_BYTE,
        TCIP_H_STOP
    } tcip_host_state_t;

    typedef enum logic [2:0] {
        TCIP_K_ADDR_W,
        TCIP_K_REG,
        TCIP_K_WDATA,
        TCIP_K_ADDR_R,
        TCIP_K_RDATA
    } tcip_kind_t;

endpackage : tcip_pkg

/* design/tcip_if.sv */
// Two-wire bus between controller and target, open-drain data line
interface tcip_if;
    logic scl_drv;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl_level;
    logic sda_level;

    // Pull-up: line is low only while some party drives a low
    assign scl_level = scl_drv;
    assign sda_level = ~((host_sda_oe & ~host_sda_out) |
                         (dev_sda_oe & ~dev_sda_out));

    modport host (
        output scl_drv,
        output host_sda_out,
        output host_sda_oe,
        input sda_level
    );

    modport dev (
        input scl_level,
        input sda_level,
        output dev_sda_out,
        output dev_sda_oe
    );
endinterface : tcip_if

/* design/tcip_target.sv */
// Target end: start/stop detection, address match, byte transfer
module tcip_target (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    tcip_if.dev bus,
    output logic [7:0] reg_addr_out,
    output logic [7:0] wr_data_out,
    output logic wr_strobe_out,
    output logic rd_strobe_out,
    input wire logic [7:0] rd_data_in,
    output logic busy_out
);

    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        next_ptr = p + 8'h01;
    endfunction : next_ptr

    // Two-stage synchronisers, then one more stage for edges
    logic [1:0] scl_sy_q;
    logic [1:0] sda_sy_q;
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_sy_q <= {scl_sy_q[0], bus.scl_level};
            sda_sy_q <= {sda_sy_q[0], bus.sda_level};
            scl_p_q <= scl_sy_q[1];
            sda_p_q <= sda_sy_q[1];
        end
    end

    wire scl_s = scl_sy_q[1];
    wire sda_s = sda_sy_q[1];
    // Sample point and drive point of each bit
    wire scl_rise = scl_s & ~scl_p_q; // RQ10
    wire scl_fall = ~scl_s & scl_p_q; // RQ10
    wire clk_high = scl_s & scl_p_q;
    wire start_det = clk_high & sda_p_q & ~sda_s; // RQ3
    wire stop_det = clk_high & ~sda_p_q & sda_s; // RQ4

    tcip_pkg::tcip_tgt_state_t state_q;
    tcip_pkg::tcip_tgt_state_t state_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] wdat_q;
    logic [7:0] wdat_d;
    logic oe_q;
    logic oe_d;
    logic rw_q;
    logic rw_d;
    logic full_q;
    logic full_d;
    logic wr_q;
    logic wr_d;
    logic rd_q;
    logic rd_d;

    wire addr_hit = shift_q[7:1] == tcip_pkg::TGT_ADDR; // RQ2
    wire last_in = bit_q == tcip_pkg::LAST_BIT;
    wire [7:0] shifted_in = {shift_q[6:0], sda_s};
    wire master_ack = sda_s == tcip_pkg::BIT_ACK;

    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        wdat_d = wdat_q;
        oe_d = oe_q;
        rw_d = rw_q;
        full_d = full_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        if (stop_det) begin
            // Transfer over, release line, wait for start
            state_d = tcip_pkg::TCIP_T_IDLE; // RQ4
            oe_d = 1'b0;
            full_d = 1'b0;
        end else if (start_det) begin
            // Also a repeated start in the middle of a transfer
            state_d = tcip_pkg::TCIP_T_ADDR; // RQ3
            bit_d = 3'h0;
            full_d = 1'b0;
            oe_d = 1'b0;
        end else begin
            unique case (state_q)
                tcip_pkg::TCIP_T_IDLE: begin
                    oe_d = 1'b0;
                end
                tcip_pkg::TCIP_T_ADDR,
                tcip_pkg::TCIP_T_REG,
                tcip_pkg::TCIP_T_WDATA: begin
                    if (scl_rise) begin
                        // Bytes arrive most significant bit first
                        shift_d = shifted_in; // RQ5
                        bit_d = bit_q + 3'h1;
                        full_d = last_in;
                    end else if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        bit_d = 3'h0;
                        if (state_q == tcip_pkg::TCIP_T_ADDR) begin
                            if (addr_hit) begin
                                oe_d = 1'b1; // RQ6
                                rw_d = shift_q[0]; // RQ1
                                state_d = tcip_pkg::TCIP_T_ACK_ADDR;
                            end else begin
                                state_d = tcip_pkg::TCIP_T_IDLE; // RQ2
                            end
                        end else if (state_q == tcip_pkg::TCIP_T_REG) begin
                            ptr_d = shift_q;
                            oe_d = 1'b1; // RQ8
                            state_d = tcip_pkg::TCIP_T_ACK_REG;
                        end else begin
                            wdat_d = shift_q;
                            wr_d = 1'b1;
                            oe_d = 1'b1; // RQ9
                            state_d = tcip_pkg::TCIP_T_ACK_W;
                        end
                    end
                end
                tcip_pkg::TCIP_T_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rw_q == tcip_pkg::DIR_READ) begin
                            // Read from the pointer left by the write
                            shift_d = rd_data_in; // RQ12
                            rd_d = 1'b1;
                            oe_d = ~rd_data_in[7];
                            state_d = tcip_pkg::TCIP_T_RDATA;
                        end else begin
                            oe_d = 1'b0;
                            state_d = tcip_pkg::TCIP_T_REG;
                        end
                    end
                end
                tcip_pkg::TCIP_T_ACK_REG: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        state_d = tcip_pkg::TCIP_T_WDATA;
                    end
                end
                tcip_pkg::TCIP_T_ACK_W: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        ptr_d = next_ptr(ptr_q); // RQ15
                        state_d = tcip_pkg::TCIP_T_WDATA; // RQ13
                    end
                end
                tcip_pkg::TCIP_T_RDATA: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 3'h1;
                        full_d = last_in;
                    end else if (scl_fall) begin
                        if (full_q) begin
                            // Free the line for the controller's answer
                            full_d = 1'b0;
                            oe_d = 1'b0;
                            state_d = tcip_pkg::TCIP_T_RACK;
                        end else begin
                            oe_d = ~shift_q[6]; // RQ10
                            shift_d = {shift_q[6:0], 1'b0};
                        end
                    end
                end
                tcip_pkg::TCIP_T_RACK: begin
                    if (scl_rise) begin
                        if (master_ack) begin
                            ptr_d = next_ptr(ptr_q); // RQ15
                            full_d = 1'b1;
                        end else begin
                            // Not acknowledged: wait idle for the stop
                            state_d = tcip_pkg::TCIP_T_IDLE; // RQ15
                        end
                    end else if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        bit_d = 3'h0;
                        shift_d = rd_data_in; // RQ13
                        rd_d = 1'b1;
                        oe_d = ~rd_data_in[7];
                        state_d = tcip_pkg::TCIP_T_RDATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= tcip_pkg::TCIP_T_IDLE;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            ptr_q <= tcip_pkg::PTR_RESET;
            wdat_q <= 8'h00;
            oe_q <= 1'b0;
            rw_q <= tcip_pkg::DIR_WRITE;
            full_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            wdat_q <= wdat_d;
            oe_q <= oe_d;
            rw_q <= rw_d;
            full_q <= full_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Open drain: only ever pulls low; bus rate only bounded by sync delay
    assign bus.dev_sda_out = 1'b0;
    assign bus.dev_sda_oe = oe_q; // RQ14
    assign reg_addr_out = ptr_q;
    assign wr_data_out = wdat_q;
    assign wr_strobe_out = wr_q;
    assign rd_strobe_out = rd_q;
    assign busy_out = state_q != tcip_pkg::TCIP_T_IDLE;

endmodule : tcip_target

/* design/tcip_controller.sv */
// Controller end: generates bus clock, runs write and read transfers
module tcip_controller #(
    parameter int unsigned QTR_CYC = tcip_pkg::QTR_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    tcip_if.host bus,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_read_in,
    input wire logic [7:0] cmd_reg_in,
    input wire logic [3:0] cmd_len_in,
    input wire logic [7:0] wr_data_in,
    output logic wr_take_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic done_out,
    output logic nack_out
);

    logic [1:0] sda_sy_q;
    logic [15:0] tmr_q;
    logic [1:0] ph_q;
    tcip_pkg::tcip_host_state_t st_q;
    tcip_pkg::tcip_host_state_t st_d;
    tcip_pkg::tcip_kind_t kind_q;
    tcip_pkg::tcip_kind_t kind_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] left_q;
    logic [3:0] left_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] rx_q;
    logic [7:0] rx_d;
    logic [7:0] reg_q;
    logic [7:0] reg_d;
    logic rd_cmd_q;
    logic rd_cmd_d;
    logic scl_q;
    logic scl_d;
    logic sda_q;
    logic sda_d;
    logic nack_q;
    logic nack_d;
    logic take_q;
    logic take_d;
    logic rv_q;
    logic rv_d;
    logic done_q;
    logic done_d;
    logic [7:0] rdat_q;
    logic [7:0] rdat_d;

    wire sda_s = sda_sy_q[1];
    wire idle = st_q == tcip_pkg::TCIP_H_IDLE;
    wire tick = !idle && (tmr_q == 16'(QTR_CYC - 1)); // RQ14
    wire in_ack = cnt_q == tcip_pkg::ACK_SLOT;
    wire is_rx = kind_q == tcip_pkg::TCIP_K_RDATA;
    wire last_byte = left_q == tcip_pkg::LEN_ONE;
    wire got_nack = sda_s == tcip_pkg::BIT_NACK;
    wire [7:0] addr_w = {tcip_pkg::TGT_ADDR, tcip_pkg::DIR_WRITE}; // RQ1
    wire [7:0] addr_r = {tcip_pkg::TGT_ADDR, tcip_pkg::DIR_READ}; // RQ1
    // Last read byte answered with not-acknowledge
    wire rx_ans = last_byte ? tcip_pkg::BIT_NACK : tcip_pkg::BIT_ACK;
    wire bit_val = in_ack ? (is_rx ? rx_ans : 1'b1)
                          : (is_rx ? 1'b1 : tx_q[7]);

    always_comb begin
        st_d = st_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        left_d = left_q;
        tx_d = tx_q;
        rx_d = rx_q;
        reg_d = reg_q;
        rd_cmd_d = rd_cmd_q;
        scl_d = scl_q;
        sda_d = sda_q;
        nack_d = nack_q;
        take_d = 1'b0;
        rv_d = 1'b0;
        done_d = 1'b0;
        rdat_d = rdat_q;
        if (idle) begin
            scl_d = 1'b1;
            sda_d = 1'b1; // RQ11
            if (cmd_valid_in) begin
                st_d = tcip_pkg::TCIP_H_START;
                kind_d = tcip_pkg::TCIP_K_ADDR_W;
                tx_d = addr_w; // RQ12
                reg_d = cmd_reg_in;
                rd_cmd_d = cmd_read_in;
                left_d = (cmd_len_in == 4'h0) ? tcip_pkg::LEN_ONE
                                              : cmd_len_in;
                nack_d = 1'b0;
            end
        end else if (tick) begin
            unique case (st_q)
                tcip_pkg::TCIP_H_START: begin
                    // Release, raise clock, drop data, drop clock
                    if (ph_q == 2'h0) sda_d = 1'b1;
                    if (ph_q == 2'h1) scl_d = 1'b1;
                    if (ph_q == 2'h2) sda_d = 1'b0; // RQ3
                    if (ph_q == 2'h3) begin
                        scl_d = 1'b0;
                        cnt_d = 4'h0;
                        st_d = tcip_pkg::TCIP_H_BYTE;
                    end
                end
                tcip_pkg::TCIP_H_STOP: begin
                    if (ph_q == 2'h0) sda_d = 1'b0;
                    if (ph_q == 2'h1) scl_d = 1'b1;
                    if (ph_q == 2'h2) sda_d = 1'b1; // RQ4
                    if (ph_q == 2'h3) begin
                        st_d = tcip_pkg::TCIP_H_IDLE;
                        done_d = 1'b1;
                    end
                end
                tcip_pkg::TCIP_H_BYTE: begin
                    // Data moves only a quarter after the clock fell
                    if (ph_q == 2'h0) sda_d = bit_val; // RQ10
                    if (ph_q == 2'h1) scl_d = 1'b1;
                    if (ph_q == 2'h3) begin
                        scl_d = 1'b0;
                        if (!in_ack) begin
                            tx_d = {tx_q[6:0], 1'b0}; // RQ5
                            rx_d = {rx_q[6:0], sda_s};
                            cnt_d = cnt_q + 4'h1;
                        end else begin
                            cnt_d = 4'h0;
                            if (!is_rx && got_nack) begin
                                st_d = tcip_pkg::TCIP_H_STOP; // RQ7
                                nack_d = 1'b1;
                            end else begin
                                unique case (kind_q)
                                    tcip_pkg::TCIP_K_ADDR_W: begin
                                        kind_d = tcip_pkg::TCIP_K_REG;
                                        tx_d = reg_q; // RQ8
                                    end
                                    tcip_pkg::TCIP_K_REG: begin
                                        if (rd_cmd_q) begin
                                            st_d = tcip_pkg::TCIP_H_START;
                                            kind_d = tcip_pkg::TCIP_K_ADDR_R;
                                            tx_d = addr_r; // RQ12
                                        end else begin
                                            kind_d = tcip_pkg::TCIP_K_WDATA;
                                            tx_d = wr_data_in; // RQ9
                                            take_d = 1'b1;
                                        end
                                    end
                                    tcip_pkg::TCIP_K_WDATA: begin
                                        if (last_byte) begin
                                            st_d = tcip_pkg::TCIP_H_STOP;
                                        end else begin
                                            left_d = left_q - 4'h1; // RQ13
                                            tx_d = wr_data_in;
                                            take_d = 1'b1;
                                        end
                                    end
                                    tcip_pkg::TCIP_K_ADDR_R: begin
                                        kind_d = tcip_pkg::TCIP_K_RDATA;
                                    end
                                    tcip_pkg::TCIP_K_RDATA: begin
                                        rdat_d = rx_q;
                                        rv_d = 1'b1;
                                        if (last_byte) begin
                                            st_d = tcip_pkg::TCIP_H_STOP;
                                        end else begin
                                            left_d = left_q - 4'h1; // RQ13
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                end
                default: begin
                    st_d = tcip_pkg::TCIP_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sda_sy_q <= 2'h3;
            tmr_q <= 16'h0000;
            ph_q <= 2'h0;
        end else begin
            sda_sy_q <= {sda_sy_q[0], bus.sda_level};
            tmr_q <= (idle || tick) ? 16'h0000 : tmr_q + 16'h0001;
            ph_q <= idle ? 2'h0 : (tick ? ph_q + 2'h1 : ph_q);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_q <= tcip_pkg::TCIP_H_IDLE;
            kind_q <= tcip_pkg::TCIP_K_ADDR_W;
            cnt_q <= 4'h0;
            left_q <= tcip_pkg::LEN_ONE;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            reg_q <= 8'h00;
            rd_cmd_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            nack_q <= 1'b0;
            take_q <= 1'b0;
            rv_q <= 1'b0;
            done_q <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            left_q <= left_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            reg_q <= reg_d;
            rd_cmd_q <= rd_cmd_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            nack_q <= nack_d;
            take_q <= take_d;
            rv_q <= rv_d;
            done_q <= done_d;
            rdat_q <= rdat_d;
        end
    end

    assign bus.scl_drv = scl_q;
    assign bus.host_sda_out = 1'b0;
    assign bus.host_sda_oe = ~sda_q; // RQ11
    assign cmd_ready_out = idle;
    assign wr_take_out = take_q;
    assign rd_data_out = rdat_q;
    assign rd_valid_out = rv_q;
    assign done_out = done_q;
    assign nack_out = nack_q;

endmodule : tcip_controller

/* testbench/tcip_props.sv */
// Checker for the two-wire link between controller and target
module tcip_props (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic scl_drv,
    input wire logic host_sda_out,
    input wire logic host_sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic scl_level,
    input wire logic sda_level
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    logic scl_p_q, sda_p_q, first_q, dir_q;
    logic [3:0] nbit_q;
    logic [7:0] sh_q;
    wire scl_rise = scl_level & ~scl_p_q;
    wire start = scl_level & scl_p_q & sda_p_q & ~sda_level;
    wire stop = scl_level & scl_p_q & ~sda_p_q & sda_level;
    wire ack_slot = scl_rise & (nbit_q == 4'h8);

    // Bit position and address capture since the last start
    always_ff @(posedge sys_clk_in) begin
        scl_p_q <= scl_level;
        sda_p_q <= sda_level;
        if (rst_in || start) begin
            nbit_q <= 4'h0;
            first_q <= 1'b1;
        end else if (ack_slot) begin
            nbit_q <= 4'h0;
            first_q <= 1'b0;
            if (first_q) dir_q <= sh_q[0];
        end else if (scl_rise) begin
            nbit_q <= nbit_q + 4'h1;
            sh_q <= {sh_q[6:0], sda_level};
        end
    end

    a_dev_low_only: assert property (dev_sda_oe |-> !dev_sda_out)
        else $error("target drives data line high");
    a_host_low_only: assert property (host_sda_oe |-> !host_sda_out)
        else $error("controller drives data line high");
    a_dev_oe_steady: assert property (
        scl_level && scl_p_q |-> $stable(dev_sda_oe))
        else $error("target changed data while clock high");
    a_dev_rise_low: assert property ($rose(dev_sda_oe) |-> !scl_level)
        else $error("target pulled data with clock high");
    a_reset_idle: assert property (disable iff (1'b0)
        rst_in |=> scl_drv && !dev_sda_oe && !host_sda_oe)
        else $error("link not idle in reset");
    a_stop_quiet: assert property (stop |=> !dev_sda_oe [*8])
        else $error("target drives after stop");
    a_addr_ack: assert property (ack_slot && first_q |->
        sda_level == (sh_q[7:1] != tcip_pkg::TGT_ADDR))
        else $error("address acknowledge wrong");
    a_data_ack: assert property (
        ack_slot && !first_q && !dir_q |-> !sda_level)
        else $error("written byte not acknowledged");
    a_scl_high_len: assert property (
        $rose(scl_level) |-> scl_level [*8])
        else $error("clock high phase too short");
    a_scl_low_len: assert property (
        $fell(scl_level) |-> !scl_level [*6])
        else $error("clock low phase too short");

    c_write_ack: cover property (ack_slot && !first_q && !dir_q);
    c_read_dir: cover property (ack_slot && first_q && sh_q[0]);
    c_stop: cover property (stop);
endmodule : tcip_props

/* testbench/touch_ctrl_i2c_target_port_tb_top.sv */
// Testbench joining controller and target ends over the link
module touch_ctrl_i2c_target_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0;
    logic cmd_read_in = 1'b0, cmd_ready_out, wr_take_out, rd_valid_out;
    logic done_out, nack_out, wr_strobe_out, rd_strobe_out, busy_out;
    logic [7:0] cmd_reg_in = 8'h00, rd_data_out, reg_addr_out, wr_data_out;
    logic [3:0] cmd_len_in = 4'h0;
    logic [7:0] wdat [4];
    int widx = 0, n_rd = 0, n_fail = 0, tests_run = 0, seed = 32'h51f7;
    logic [15:0] wq [$];
    logic [15:0] rq [$];
    wire [7:0] wr_data_in = wdat[widx[1:0]];
    wire [7:0] rd_data_in = reg_addr_out ^ 8'h5a;

    tcip_if bus ();
    tcip_controller #(.QTR_CYC(8)) tcip_controller_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus),
        .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
        .cmd_read_in(cmd_read_in), .cmd_reg_in(cmd_reg_in),
        .cmd_len_in(cmd_len_in), .wr_data_in(wr_data_in),
        .wr_take_out(wr_take_out), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .done_out(done_out),
        .nack_out(nack_out));
    tcip_target tcip_target_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus),
        .reg_addr_out(reg_addr_out), .wr_data_out(wr_data_out),
        .wr_strobe_out(wr_strobe_out), .rd_strobe_out(rd_strobe_out),
        .rd_data_in(rd_data_in), .busy_out(busy_out));
    tcip_props tcip_props_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_drv(bus.scl_drv),
        .host_sda_out(bus.host_sda_out), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_out(bus.dev_sda_out), .dev_sda_oe(bus.dev_sda_oe),
        .scl_level(bus.scl_level), .sda_level(bus.sda_level));

    always #2 sys_clk_in = ~sys_clk_in;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Next write byte once the controller has taken one
    always @(negedge sys_clk_in) begin
        if (wr_take_out === 1'b1) widx <= widx + 1;
        if (rd_strobe_out === 1'b1) n_rd <= n_rd + 1;
    end

    // Compare each result against the oldest note
    always @(negedge sys_clk_in) begin
        if (wr_strobe_out === 1'b1)
            check({reg_addr_out, wr_data_out},
                  wq.size() ? wq.pop_front() : 16'hxxxx);
        if (rd_valid_out === 1'b1)
            check({8'h00, rd_data_out},
                  rq.size() ? rq.pop_front() : 16'hxxxx);
    end

    task automatic run(input logic rd, input logic [3:0] len);
        logic [7:0] r;
        int n;
        int k;
        int base;
        int rd0;
        r = 8'($random(seed)) & 8'h7f;
        n = (len == 4'h0) ? 1 : len;
        base = widx;
        rd0 = n_rd;
        for (int i = 0; i < n; i++) begin
            wdat[2'(base + i)] = 8'($random(seed));
            if (rd) rq.push_back({8'h00, (r + 8'(i)) ^ 8'h5a});
            else wq.push_back({r + 8'(i), wdat[2'(base + i)]});
        end
        @(negedge sys_clk_in);
        cmd_valid_in = 1'b1;
        cmd_read_in = rd;
        cmd_reg_in = r;
        cmd_len_in = len;
        @(negedge sys_clk_in);
        cmd_valid_in = 1'b0;
        k = 0;
        while (done_out !== 1'b1 && k < 20000) begin
            @(negedge sys_clk_in);
            k++;
        end
        check({15'h0, done_out}, 16'h0001);
        check({15'h0, nack_out}, 16'h0000);
        repeat (8) @(negedge sys_clk_in);
        check({15'h0, busy_out}, 16'h0000);
        check({15'h0, cmd_ready_out}, 16'h0001);
        check(16'(widx - base), 16'(rd ? 0 : n));
        check(16'(n_rd - rd0), 16'(rd ? n : 0));
        check({8'h00, reg_addr_out}, {8'h00, r + 8'(rd ? n - 1 : n)});
    endtask : run

    initial begin
        repeat (6) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            run(1'b0, 4'(i));
            run(1'b1, 4'(i));
        end
        check(16'(wq.size() + rq.size()), 16'h0000);
        results();
    end

    initial begin
        repeat (90000) @(posedge sys_clk_in);
        n_fail++;
        results();
    end
endmodule : touch_ctrl_i2c_target_port_tb_top
